// ---- tioc_pkg.sv ----
package tioc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CH0_HIGH = 8'h00;
  localparam logic [7:0] ADDR_CH0_LOW = 8'h04;
  localparam logic [7:0] ADDR_CH1 = 8'h08;
  localparam logic [7:0] ADDR_CH2 = 8'h0c;
  localparam logic [7:0] ADDR_MODE0 = 8'h10;
  localparam logic [7:0] ADDR_CNT0 = 8'h14;
  localparam logic [7:0] ADDR_CNT1 = 8'h18;
  localparam logic [7:0] ADDR_CNT2 = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_GR_BASE = 8'h40;
  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] IOCTL_RESET = 8'h00;
  localparam logic [7:0] CH0_HIGH_MASK = 8'h7f;
  localparam logic [7:0] CH0_LOW_MASK = 8'h7f;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int MODE_BFA_BIT = 0;
  localparam int MODE_BFB_BIT = 1;
  localparam int NUM_GR = 8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ==========================================================
  // Function codes
  localparam logic [3:0] CAP_RISE = 4'h8;
  localparam logic [3:0] CAP_FALL = 4'h9;
  localparam logic [3:0] CAP_BOTH = 4'ha;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
endpackage

// ---- tioc_channel_reg.sv ----
`timescale 1ns/1ps
// ==========================================================
// One general register with compare/capture behaviour
module tioc_channel_reg (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] func,
  input wire logic cap_capable,
  input wire logic inhibit,
  input wire logic [15:0] count,
  input wire logic pin_in,
  input wire logic ch1_count_tick,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value,
  output logic pin_out,
  output logic pin_oe,
  output logic event_pulse
);
  logic pin_prev_reg;
  logic [3:0] func_prev_reg;
  logic cap_mode;
  logic cap_event;
  logic match;
  logic [1:0] action;

  always_comb begin
    cap_mode = cap_capable & func[3];
    action = func[1:0];
    match = !cap_mode && (count == value);
    cap_event = 1'b0;
    if (cap_mode) begin
      if (func[2]) begin
        cap_event = ch1_count_tick;
      end else begin
        case (func)
          tioc_pkg::CAP_RISE: cap_event = pin_in & ~pin_prev_reg;
          tioc_pkg::CAP_FALL: cap_event = ~pin_in & pin_prev_reg;
          tioc_pkg::CAP_BOTH: cap_event = pin_in ^ pin_prev_reg;
          default: cap_event = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  // Last function code, so a new code restarts its initial level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      func_prev_reg <= 4'h0;
    end else begin
      func_prev_reg <= func;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value <= 16'h0000;
    end else if (wr_en) begin
      value <= wr_data;
    end else if (cap_event && !inhibit) begin
      value <= count;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (inhibit || cap_mode || action == tioc_pkg::ACT_NONE) begin
      pin_out <= func[2] & ~cap_mode;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= 1'b1;
      if (!pin_oe || func != func_prev_reg) begin
        pin_out <= func[2];
      end else if (match) begin
        case (action)
          tioc_pkg::ACT_LOW: pin_out <= 1'b0;
          tioc_pkg::ACT_HIGH: pin_out <= 1'b1;
          tioc_pkg::ACT_TOGGLE: pin_out <= ~pin_out;
          default: pin_out <= pin_out;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= !inhibit
        && (cap_event || (match && !cap_mode));
    end
  end
endmodule

// ---- tioc_timer_io_control.sv ----
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module tioc_timer_io_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] ch0_count,
  input wire logic [15:0] channel1_counter,
  input wire logic [15:0] ch2_count,
  input wire logic ch1_count_tick,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic irq
);
  // ==========================================================
  // Register state
  logic [7:0] ch0_io_control_high_reg;
  logic [7:0] ch0_io_control_low_reg;
  logic [7:0] ch1_io_control_reg;
  logic [7:0] ch2_io_control_reg;
  logic [1:0] ch0_mode_register_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic [7:0] status_next;
  logic wr_access;
  logic rd_access;
  logic [31:0] rd_data;
  logic addr_ok;
  logic [7:0] gr_events;
  logic [7:0] gr_pin_out;
  logic [7:0] gr_pin_oe;
  logic [15:0] gr_value [tioc_pkg::NUM_GR];
  logic [3:0] gr_func [tioc_pkg::NUM_GR];
  logic [15:0] gr_count [tioc_pkg::NUM_GR];
  logic [tioc_pkg::NUM_GR-1:0] gr_cap_capable;
  logic [tioc_pkg::NUM_GR-1:0] gr_inhibit;
  logic [tioc_pkg::NUM_GR-1:0] gr_wr;
  logic buffer_a;
  logic buffer_b;

  function automatic logic is_gr_addr(input logic [7:0] a);
    return a[7:5] == tioc_pkg::ADDR_GR_BASE[7:5] && a[1:0] == 2'h0;
  endfunction

  // ==========================================================
  // APB decode
  always_comb begin
    wr_access = psel && penable && pwrite;
    rd_access = psel && !pwrite;
    buffer_a = ch0_mode_register_reg[tioc_pkg::MODE_BFA_BIT];
    buffer_b = ch0_mode_register_reg[tioc_pkg::MODE_BFB_BIT];
  end

  always_comb begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      tioc_pkg::ADDR_CH0_HIGH: rd_data[7:0] = ch0_io_control_high_reg;
      tioc_pkg::ADDR_CH0_LOW: rd_data[7:0] = ch0_io_control_low_reg;
      tioc_pkg::ADDR_CH1: rd_data[7:0] = ch1_io_control_reg;
      tioc_pkg::ADDR_CH2: rd_data[7:0] = ch2_io_control_reg;
      tioc_pkg::ADDR_MODE0: rd_data[1:0] = ch0_mode_register_reg;
      tioc_pkg::ADDR_CNT0: rd_data[15:0] = ch0_count;
      tioc_pkg::ADDR_CNT1: rd_data[15:0] = channel1_counter;
      tioc_pkg::ADDR_CNT2: rd_data[15:0] = ch2_count;
      tioc_pkg::ADDR_STATUS: rd_data[7:0] = status_reg;
      tioc_pkg::ADDR_MASK: rd_data[7:0] = mask_reg;
      default: begin
        if (is_gr_addr(paddr)) begin
          rd_data[15:0] = gr_value[paddr[4:2]];
        end else begin
          addr_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_access && !penable) begin
        prdata <= rd_data;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch0_io_control_high_reg <= tioc_pkg::IOCTL_RESET;
      ch0_io_control_low_reg <= tioc_pkg::IOCTL_RESET;
      ch1_io_control_reg <= tioc_pkg::IOCTL_RESET;
      ch2_io_control_reg <= tioc_pkg::IOCTL_RESET;
      ch0_mode_register_reg <= tioc_pkg::MODE_RESET;
      mask_reg <= tioc_pkg::STATUS_RESET;
    end else if (wr_access && pready) begin
      case (paddr)
        tioc_pkg::ADDR_CH0_HIGH:
          ch0_io_control_high_reg <=
            pwdata[7:0] & tioc_pkg::CH0_HIGH_MASK;
        tioc_pkg::ADDR_CH0_LOW:
          ch0_io_control_low_reg <=
            pwdata[7:0] & tioc_pkg::CH0_LOW_MASK;
        tioc_pkg::ADDR_CH1: ch1_io_control_reg <= pwdata[7:0];
        tioc_pkg::ADDR_CH2: ch2_io_control_reg <= pwdata[7:0];
        tioc_pkg::ADDR_MODE0: ch0_mode_register_reg <= pwdata[1:0];
        tioc_pkg::ADDR_MASK: mask_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Function field routing, order: c0 first, second, third, fourth,
  // c1 first, second, c2 first, second
  always_comb begin
    gr_func[0] = ch0_io_control_high_reg[3:0];
    gr_func[1] = {1'b0, ch0_io_control_high_reg[6:4]};
    gr_func[2] = ch0_io_control_low_reg[3:0];
    gr_func[3] = {1'b0, ch0_io_control_low_reg[6:4]};
    gr_func[4] = ch1_io_control_reg[3:0];
    gr_func[5] = ch1_io_control_reg[7:4];
    gr_func[6] = ch2_io_control_reg[3:0];
    gr_func[7] = ch2_io_control_reg[7:4];
    gr_cap_capable = 8'h05;
    gr_inhibit = 8'h00;
    gr_inhibit[2] = buffer_a;
    gr_inhibit[3] = buffer_b;
    gr_count[0] = ch0_count;
    gr_count[1] = ch0_count;
    gr_count[2] = ch0_count;
    gr_count[3] = ch0_count;
    gr_count[4] = channel1_counter;
    gr_count[5] = channel1_counter;
    gr_count[6] = ch2_count;
    gr_count[7] = ch2_count;
    for (int i = 0; i < tioc_pkg::NUM_GR; i++) begin
      gr_wr[i] = wr_access && pready && is_gr_addr(paddr)
        && paddr[4:2] == 3'(i);
    end
  end

  for (genvar g = 0; g < tioc_pkg::NUM_GR; g++) begin : gen_gr
    tioc_channel_reg u_gr (
      .clk(clk),
      .rstn(rstn),
      .func(gr_func[g]),
      .cap_capable(gr_cap_capable[g]),
      .inhibit(gr_inhibit[g]),
      .count(gr_count[g]),
      .pin_in(pin_in[g]),
      .ch1_count_tick(ch1_count_tick),
      .wr_en(gr_wr[g]),
      .wr_data(pwdata[15:0]),
      .value(gr_value[g]),
      .pin_out(gr_pin_out[g]),
      .pin_oe(gr_pin_oe[g]),
      .event_pulse(gr_events[g])
    );
  end

  // ==========================================================
  // Pins and interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end else begin
      pin_out <= gr_pin_out;
      pin_oe <= gr_pin_oe;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (wr_access && pready && paddr == tioc_pkg::ADDR_STATUS) begin
      status_next = status_next & ~pwdata[7:0];
    end
    status_next = status_next | gr_events;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= tioc_pkg::STATUS_RESET;
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end
endmodule

// ---- tioc_assertions.sv ----
`timescale 1ns/1ps
// =====
// Bus and pin checks
module tioc_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin_oe,
  input wire logic irq
);
  logic [7:0] sh_reg;
  logic rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign rd = pready && !pwrite;
  // Shadow of the channel 0 high control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_reg <= 8'h00;
    end else if (pready && pwrite && paddr == tioc_pkg::ADDR_CH0_HIGH) begin
      sh_reg <= pwdata[7:0];
    end
  end
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  unmapped_err_a: assert property (psel && !penable && paddr == 8'h30
    |=> pslverr) else $error("unmapped not refused");
  high_rsvd_a: assert property (
    rd && paddr == tioc_pkg::ADDR_CH0_HIGH |-> !prdata[7])
    else $error("high bit 7 set");
  low_rsvd_a: assert property (
    rd && paddr == tioc_pkg::ADDR_CH0_LOW |-> !prdata[7])
    else $error("low bit 7 set");
  ctrl_upper_a: assert property (
    rd && paddr <= tioc_pkg::ADDR_CH2 |-> prdata[31:8] == 24'h0)
    else $error("control upper bits set");
  cap_no_drive_a: assert property (
    sh_reg[3] && $stable(sh_reg) && sh_reg == $past(sh_reg, 2)
    |-> !pin_oe[0])
    else $error("capture pin driven");
  off_no_drive_a: assert property (
    !sh_reg[3] && sh_reg[1:0] == 2'h0 && $stable(sh_reg)
    && sh_reg == $past(sh_reg, 2) |-> !pin_oe[0])
    else $error("disabled pin driven");
  cmp_drive_a: assert property (
    !sh_reg[3] && sh_reg[1:0] != 2'h0 && $stable(sh_reg)
    && sh_reg == $past(sh_reg, 2) |-> pin_oe[0])
    else $error("compare pin not driven");
  cover property (irq);
  cover property (pslverr);
  cover property (sh_reg[3] && $stable(sh_reg));
endmodule
bind tioc_timer_io_control tioc_assertions i_tioc_assertions (.clk, .rstn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pin_oe, .irq);

// ---- tioc_pin_model.sv ----
`timescale 1ns/1ps
// =====
// Outside drivers of the timer pins
module tioc_pin_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] flip,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  logic [7:0] ext_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_reg <= 8'h00;
    end else begin
      ext_reg <= ext_reg ^ flip;
    end
  end
  // Pad level: the block wins where it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_reg);
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// =====
// Top of the bench
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
  logic [7:0] paddr = 8'h00, flip = 8'h00, a;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic pready, pslverr, irq, e;
  logic [15:0] cnt0 = 16'h0, cnt1 = 16'h0, cnt2 = 16'h0;
  logic [7:0] pin_in, pin_out, pin_oe;
  logic [7:0] ctl [4] = '{tioc_pkg::ADDR_CH0_HIGH, tioc_pkg::ADDR_CH0_LOW,
    tioc_pkg::ADDR_CH1, tioc_pkg::ADDR_CH2};
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  tioc_timer_io_control i_tioc_timer_io_control (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ch0_count(cnt0), .channel1_counter(cnt1), .ch2_count(cnt2),
    .ch1_count_tick(tick), .pin_in, .pin_out, .pin_oe, .irq);
  tioc_pin_model i_tioc_pin_model (.clk, .rstn, .flip, .pin_out, .pin_oe,
    .pin_in);
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(q, x);
  endtask
  task automatic pulse(input logic [7:0] m, input logic t, input int k);
    @(posedge clk);
    flip <= m;
    tick <= t;
    @(posedge clk);
    flip <= 8'h00;
    tick <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  function automatic logic [7:0] rmask(input logic [7:0] ad);
    return (ad == ctl[0] || ad == ctl[1]) ? 8'h7f : 8'hff;
  endfunction
  // Expected {enable, level} of a compare pin
  function automatic logic [1:0] exp_pin(input logic [2:0] c, input bit hit);
    if (c[1:0] == 2'h0) return 2'b00;
    if (!hit) return {1'b1, c[2]};
    return {1'b1, c[1:0] == 2'h1 ? 1'b0 : c[1:0] == 2'h2 ? 1'b1 : !c[2]};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    q = $urandom(32'hc5d6);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cnt1 <= 16'($urandom);
    cnt2 <= 16'($urandom);
    foreach (ctl[i]) rd(ctl[i], 32'h0);
    repeat (16) begin
      a = ctl[$urandom_range(3)];
      d = $urandom & {24'hffffff, rmask(a)};
      wr(a, d);
      rd(a, {24'h0, d[7:0] & rmask(a)});
    end
    foreach (ctl[i]) wr(ctl[i], 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({q[30:0], e}, 32'h1);
    for (int c = 8; c <= 10; c++) begin
      wr(tioc_pkg::ADDR_CH0_HIGH, 32'(c));
      wr(tioc_pkg::ADDR_GR_BASE, 32'h0);
      cnt0 <= 16'($urandom);
      pulse(8'h01, 1'b0, 4);
      rd(tioc_pkg::ADDR_GR_BASE,
        c == 9 ? 32'h0 : {16'h0, cnt0});
      wr(tioc_pkg::ADDR_GR_BASE, 32'h0);
      cnt0 <= 16'($urandom);
      pulse(8'h01, 1'b0, 4);
      rd(tioc_pkg::ADDR_GR_BASE,
        c == 8 ? 32'h0 : {16'h0, cnt0});
    end
    wr(tioc_pkg::ADDR_CH0_LOW, 32'h0c);
    cnt0 <= 16'($urandom);
    pulse(8'h00, 1'b1, 2);
    rd(tioc_pkg::ADDR_GR_BASE + 8'h08, {16'h0, cnt0});
    wr(tioc_pkg::ADDR_MODE0, 32'h1);
    wr(tioc_pkg::ADDR_GR_BASE + 8'h08, 32'h0);
    pulse(8'h00, 1'b1, 2);
    rd(tioc_pkg::ADDR_GR_BASE + 8'h08, 32'h0);
    wr(tioc_pkg::ADDR_MODE0, 32'h0);
    wr(tioc_pkg::ADDR_GR_BASE, 32'h1234);
    cnt0 <= 16'h0;
    for (int c = 1; c < 8; c++) begin
      wr(tioc_pkg::ADDR_CH0_HIGH, 32'(c));
      repeat (3) @(posedge clk);
      chk({pin_oe[0], pin_oe[0] & pin_out[0]},
        exp_pin(c, 0));
      cnt0 <= 16'h1234;
      @(posedge clk);
      cnt0 <= 16'h0;
      repeat (2) @(posedge clk);
      chk({pin_oe[0], pin_oe[0] & pin_out[0]}, exp_pin(c, 1));
    end
    chk(irq, 1'b0);
    wr(tioc_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(tioc_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    summarize();
  end
endmodule
